// File: pkg/acm_defs.svh
/*
 * Constants of the activity counter monitor: offsets, field positions,
 * reset values and fixed event numbers.
 * Assumes inclusion by bare name wherever these values are needed.
 */
`ifndef ACM_DEFS_SVH
`define ACM_DEFS_SVH

`define ACM_NUM_CNT       5
`define ACM_CNT_W         64
`define ACM_ADDR_W        12
`define ACM_INC_W         2

`define ACM_OFF_CNT       12'h000
`define ACM_OFF_TYPE      12'h040
`define ACM_OFF_CNTEN     12'h080
`define ACM_OFF_AUX2      12'h090
`define ACM_OFF_AUX3      12'h098
`define ACM_OFF_AUX32     12'h0A0
`define ACM_OFF_HAUX32    12'h0A8

`define ACM_MON_EN_BIT    4
`define ACM_EVT_FIELD_W   16

`define ACM_EVT0          16'h0011
`define ACM_EVT1          16'h00EF
`define ACM_EVT2          16'h0008
`define ACM_EVT3          16'h00F0
`define ACM_EVT4          16'h00F1

`define ACM_AUX_RST       32'h0000_0000
`define ACM_CNTEN_RST     5'h1F
`define ACM_CNT_RST       64'h0000_0000_0000_0000

`endif

// File: pkg/acm_pkg.sv
/*
 * Types of the activity counter monitor: carriers and state records.
 * Assumes acm_defs.svh is on the include path.
 */
`include "acm_defs.svh"

package acm_pkg;

	typedef enum logic [2:0]
	{
		ACM_MISS_IDLE  = 3'b001,
		ACM_MISS_COUNT = 3'b010,
		ACM_MISS_DRAIN = 3'b100
	} acm_miss_t;

	typedef struct packed
	{
		logic                  coreClkRun;
		logic [`ACM_INC_W-1:0] instRetired;
		logic                  missOutstanding;
		logic                  missDataReturn;
		logic [`ACM_INC_W-1:0] powerHint;
	} acm_events_t;

	typedef struct packed
	{
		logic [`ACM_ADDR_W-1:0] addr;
		logic [`ACM_CNT_W-1:0]  wdata;
		logic                   wr;
		logic                   rd;
		logic [1:0]             level;
	} acm_sysreq_t;

	typedef struct packed
	{
		logic [`ACM_ADDR_W-1:0] addr;
		logic                   rd;
	} acm_dbgreq_t;

	typedef struct packed
	{
		logic [`ACM_CNT_W-1:0] value;
	} acm_cnt_state_t;

	typedef struct packed
	{
		logic [31:0]              auxLevel2;
		logic [31:0]              auxLevel3;
		logic [31:0]              aux32;
		logic [31:0]              hypAux32;
		logic [`ACM_NUM_CNT-1:0]  cntEnable;
		acm_miss_t                missState;
		logic                     missPrev;
		logic                     constSync1;
		logic                     constSync2;
		logic                     constPrev;
		logic [`ACM_CNT_W-1:0]    sysRdata;
		logic                     sysTrap;
		logic [31:0]              dbgRdata;
	} acm_state_t;

endpackage

// File: src/acm_wrap_counter.sv
/*
 * One 64-bit wrapping activity counter with load.
 * Assumes increments and loads come from logic on the same clock.
 */
`timescale 1ns/1ps
`include "acm_defs.svh"

module acm_wrap_counter
(
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic [`ACM_INC_W-1:0] incAmount,
	input  wire logic                  load,
	input  wire logic [`ACM_CNT_W-1:0] loadValue,
	output logic      [`ACM_CNT_W-1:0] count
);

	acm_pkg::acm_cnt_state_t state_reg;
	acm_pkg::acm_cnt_state_t state_next;

	// ********************
	// Next value
	// ********************
	always_comb
	begin
		state_next = state_reg;
		if (load)
		begin
			state_next.value = loadValue;
		end
		else
		begin
			// Plain modulo sum: wraps to zero, no flag kept
			state_next.value = state_reg.value + {{(`ACM_CNT_W-`ACM_INC_W){1'b0}}, incAmount};
		end
	end

	// ********************
	// Storage
	// ********************
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg.value <= `ACM_CNT_RST;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign count = state_reg.value;

endmodule

// File: src/acm_activity_monitor.sv
/*
 * Activity counter monitor: five fixed-event 64-bit counters, system
 * register port with level traps, read-only debug port.
 * Assumes event inputs come from core logic on clk; constTickToggle comes
 * from the system counter domain and flips once per tick.
 */
// Added by the designer: the strobed register port and the register offsets.
//
// What this block does
// - Exactly five counters, zero to four, 64-bit state only.
// - Each counter is 64 bits and wraps to zero on overflow.
// - No overflow flag and no interrupt on wrap.
// - Event selects are fixed; type fields ignore writes, return fixed number.
// - Counter zero counts core clock cycles, event 0x11.
// - Counter one follows constant system counter ticks, event 0xEF.
// - Counter two counts executed instructions incl. condition fails, event 0x08.
// - Counter three counts first miss until its data returns, event 0xF0.
// - Counter four counts high power activity hints, event 0xF1.
// - Debug port reads monitor registers only; writes have no effect.
// - System register reads and writes reach the monitor registers.
// - Bit 4 of level 2 and 3 aux control enables access, else trap.
// - Bit 4 of 32-bit aux control registers reads zero, ignores writes.
// - Configuration only from the highest level; counters read-only otherwise.
// - Core-clocked counters stop while the core clock is stopped.
//
`timescale 1ns/1ps
`include "acm_defs.svh"

module acm_activity_monitor
(
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire acm_pkg::acm_events_t  events,
	input  wire logic                  constTickToggle,
	input  wire acm_pkg::acm_sysreq_t  sysReq,
	output logic      [`ACM_CNT_W-1:0] sysRdata,
	output logic                       sysTrap,
	input  wire acm_pkg::acm_dbgreq_t  dbgReq,
	output logic      [31:0]           dbgRdata
);

	acm_pkg::acm_state_t     state_reg;
	acm_pkg::acm_state_t     state_next;
	logic [`ACM_CNT_W-1:0]   cntValue [`ACM_NUM_CNT];
	logic [`ACM_INC_W-1:0]   cntInc   [`ACM_NUM_CNT];
	logic [`ACM_NUM_CNT-1:0] cntLoad;
	logic                    constTick;
	logic                    coreRun;
	logic                    sysAccess;
	logic                    monTrapped;
	logic [3:0]              sysCntHit;
	logic [3:0]              sysTypeHit;
	logic [3:0]              dbgCntHit;
	logic [3:0]              dbgTypeHit;

	// ********************
	// Helpers
	// ********************
	function automatic logic [3:0] decodeIdx
	(
		input logic [`ACM_ADDR_W-1:0] a,
		input logic [`ACM_ADDR_W-1:0] base,
		input logic                   halfWords
	);
		logic ok;
		ok = (a[11:6] == base[11:6]) && (a[1:0] == 2'b00) && (halfWords || !a[2]);
		ok = ok && ({1'b0, a[5:3]} < 4'(`ACM_NUM_CNT));
		return {ok, a[5:3]};
	endfunction

	function automatic logic [`ACM_EVT_FIELD_W-1:0] eventNumber
	(
		input logic [2:0] idx
	);
		logic [`ACM_EVT_FIELD_W-1:0] n;
		n = '0;
		case (idx)
			3'd0: n = `ACM_EVT0;
			3'd1: n = `ACM_EVT1;
			3'd2: n = `ACM_EVT2;
			3'd3: n = `ACM_EVT3;
			3'd4: n = `ACM_EVT4;
			default: n = '0;
		endcase
		return n;
	endfunction

	function automatic logic [31:0] clearMonBit
	(
		input logic [31:0] v
	);
		logic [31:0] r;
		r = v;
		r[`ACM_MON_EN_BIT] = 1'b0;
		return r;
	endfunction

	// ********************
	// Decode and traps
	// ********************
	assign sysCntHit  = decodeIdx(sysReq.addr, `ACM_OFF_CNT, 1'b0);
	assign sysTypeHit = decodeIdx(sysReq.addr, `ACM_OFF_TYPE, 1'b0);
	assign dbgCntHit  = decodeIdx(dbgReq.addr, `ACM_OFF_CNT, 1'b1);
	assign dbgTypeHit = decodeIdx(dbgReq.addr, `ACM_OFF_TYPE, 1'b0);
	assign sysAccess  = sysReq.rd || sysReq.wr;
	assign coreRun    = events.coreClkRun;
	assign constTick  = state_reg.constSync2 ^ state_reg.constPrev;

	always_comb
	begin
		monTrapped = 1'b0;
		// Lower levels trap while an enabling level holds the bit clear
		if (sysReq.level < 2'd3 && !state_reg.auxLevel3[`ACM_MON_EN_BIT])
		begin
			monTrapped = 1'b1;
		end
		if (sysReq.level < 2'd2 && !state_reg.auxLevel2[`ACM_MON_EN_BIT])
		begin
			monTrapped = 1'b1;
		end
	end

	// ********************
	// Counter feeds
	// ********************
	always_comb
	begin
		cntInc[0] = `ACM_INC_W'(coreRun && state_reg.cntEnable[0]);
		cntInc[1] = `ACM_INC_W'(constTick && state_reg.cntEnable[1]);
		cntInc[2] = (coreRun && state_reg.cntEnable[2]) ? events.instRetired : '0;
		cntInc[3] = `ACM_INC_W'(coreRun && state_reg.cntEnable[3]
			&& state_reg.missState == acm_pkg::ACM_MISS_COUNT);
		cntInc[4] = (coreRun && state_reg.cntEnable[4]) ? events.powerHint : '0;
		cntLoad = '0;
		// Only the top level may preset a counter
		if (sysReq.wr && sysCntHit[3] && sysReq.level == 2'd3 && !monTrapped)
		begin
			cntLoad[sysCntHit[2:0]] = 1'b1;
		end
	end

	// ********************
	// Counters
	// ********************
	for (genvar i = 0; i < `ACM_NUM_CNT; i++)
	begin : gCnt
		acm_wrap_counter uCnt
		(
			.clk       (clk),
			.rst       (rst),
			.incAmount (cntInc[i]),
			.load      (cntLoad[i]),
			.loadValue (sysReq.wdata),
			.count     (cntValue[i])
		);
	end

	// ********************
	// Next state
	// ********************
	always_comb
	begin
		state_next = state_reg;

		// Tick crossing from the system counter domain
		state_next.constSync1 = constTickToggle;
		state_next.constSync2 = state_reg.constSync1;
		state_next.constPrev  = state_reg.constSync2;

		// First-miss tracking: count only the first miss, then drain until no miss is outstanding
		state_next.missPrev = events.missOutstanding;
		case (state_reg.missState)
			acm_pkg::ACM_MISS_IDLE:
			begin
				if (events.missOutstanding && !state_reg.missPrev)
				begin
					state_next.missState = acm_pkg::ACM_MISS_COUNT;
				end
			end
			acm_pkg::ACM_MISS_COUNT:
			begin
				if (events.missDataReturn)
				begin
					state_next.missState = events.missOutstanding
						? acm_pkg::ACM_MISS_DRAIN : acm_pkg::ACM_MISS_IDLE;
				end
			end
			acm_pkg::ACM_MISS_DRAIN:
			begin
				if (!events.missOutstanding)
				begin
					state_next.missState = acm_pkg::ACM_MISS_IDLE;
				end
			end
			default:
			begin
				state_next.missState = acm_pkg::ACM_MISS_IDLE;
			end
		endcase

		// System register port
		state_next.sysRdata = '0;
		state_next.sysTrap  = 1'b0;
		if (sysAccess)
		begin
			if (sysCntHit[3] || sysTypeHit[3] || sysReq.addr == `ACM_OFF_CNTEN)
			begin
				state_next.sysTrap = monTrapped;
				if (!monTrapped && sysReq.rd)
				begin
					if (sysCntHit[3])
					begin
						state_next.sysRdata = cntValue[sysCntHit[2:0]];
					end
					else if (sysTypeHit[3])
					begin
						state_next.sysRdata = `ACM_CNT_W'(eventNumber(sysTypeHit[2:0]));
					end
					else
					begin
						state_next.sysRdata = `ACM_CNT_W'(state_reg.cntEnable);
					end
				end
				if (!monTrapped && sysReq.wr && sysReq.level == 2'd3
					&& sysReq.addr == `ACM_OFF_CNTEN)
				begin
					state_next.cntEnable = sysReq.wdata[`ACM_NUM_CNT-1:0];
				end
			end
			else if (sysReq.addr == `ACM_OFF_AUX2)
			begin
				state_next.sysTrap = sysReq.level < 2'd2;
				if (sysReq.level >= 2'd2 && sysReq.rd)
				begin
					state_next.sysRdata = `ACM_CNT_W'(state_reg.auxLevel2);
				end
				if (sysReq.level >= 2'd2 && sysReq.wr)
				begin
					state_next.auxLevel2 = sysReq.wdata[31:0];
				end
			end
			else if (sysReq.addr == `ACM_OFF_AUX3)
			begin
				state_next.sysTrap = sysReq.level != 2'd3;
				if (sysReq.level == 2'd3 && sysReq.rd)
				begin
					state_next.sysRdata = `ACM_CNT_W'(state_reg.auxLevel3);
				end
				if (sysReq.level == 2'd3 && sysReq.wr)
				begin
					state_next.auxLevel3 = sysReq.wdata[31:0];
				end
			end
			else if (sysReq.addr == `ACM_OFF_AUX32)
			begin
				if (sysReq.rd)
				begin
					state_next.sysRdata = `ACM_CNT_W'(state_reg.aux32);
				end
				if (sysReq.wr)
				begin
					state_next.aux32 = clearMonBit(sysReq.wdata[31:0]);
				end
			end
			else if (sysReq.addr == `ACM_OFF_HAUX32)
			begin
				state_next.sysTrap = sysReq.level < 2'd2;
				if (sysReq.level >= 2'd2 && sysReq.rd)
				begin
					state_next.sysRdata = `ACM_CNT_W'(state_reg.hypAux32);
				end
				if (sysReq.level >= 2'd2 && sysReq.wr)
				begin
					state_next.hypAux32 = clearMonBit(sysReq.wdata[31:0]);
				end
			end
		end

		// Debug port: read path only, nothing is ever written
		state_next.dbgRdata = '0;
		if (dbgReq.rd)
		begin
			if (dbgCntHit[3])
			begin
				state_next.dbgRdata = dbgReq.addr[2]
					? cntValue[dbgCntHit[2:0]][63:32]
					: cntValue[dbgCntHit[2:0]][31:0];
			end
			else if (dbgTypeHit[3])
			begin
				state_next.dbgRdata = 32'(eventNumber(dbgTypeHit[2:0]));
			end
			else if (dbgReq.addr == `ACM_OFF_CNTEN)
			begin
				state_next.dbgRdata = 32'(state_reg.cntEnable);
			end
		end
	end

	// ********************
	// State register
	// ********************
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg.auxLevel2  <= `ACM_AUX_RST;
			state_reg.auxLevel3  <= `ACM_AUX_RST;
			state_reg.aux32      <= `ACM_AUX_RST;
			state_reg.hypAux32   <= `ACM_AUX_RST;
			state_reg.cntEnable  <= `ACM_CNTEN_RST;
			state_reg.missState  <= acm_pkg::ACM_MISS_IDLE;
			state_reg.missPrev   <= 1'b0;
			state_reg.constSync1 <= 1'b0;
			state_reg.constSync2 <= 1'b0;
			state_reg.constPrev  <= 1'b0;
			state_reg.sysRdata   <= '0;
			state_reg.sysTrap    <= 1'b0;
			state_reg.dbgRdata   <= '0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// ********************
	// Outputs
	// ********************
	assign sysRdata = state_reg.sysRdata;
	assign sysTrap  = state_reg.sysTrap;
	assign dbgRdata = state_reg.dbgRdata;

endmodule

// File: sim/acm_activity_monitor_asserts.sv
/*
 * Port checker of the activity counter monitor, bound to its top module.
 * Assumes acm_pkg and acm_defs.svh are compiled first.
 */
`timescale 1ns/1ps

module acm_activity_monitor_asserts
(
	input wire logic                 clk,
	input wire logic                 rst,
	input wire acm_pkg::acm_events_t events,
	input wire acm_pkg::acm_sysreq_t sysReq,
	input wire logic [63:0]          sysRdata,
	input wire logic                 sysTrap,
	input wire acm_pkg::acm_dbgreq_t dbgReq,
	input wire logic [31:0]          dbgRdata
);
	//****************
	// Read and access sequences
	//****************
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence rdRun;
		sysReq.rd && sysReq.level == 2'd3 && sysReq.addr == 12'h000 && events.coreClkRun;
	endsequence
	sequence rdStop;
		sysReq.rd && sysReq.level == 2'd3 && sysReq.addr == 12'h000 && !events.coreClkRun;
	endsequence
	sequence topAcc;
		(sysReq.rd || sysReq.wr) && sysReq.level == 2'd3;
	endsequence
	sequence rdType4;
		sysReq.rd && sysReq.level == 2'd3 && sysReq.addr == 12'h060;
	endsequence
	sequence rdDbgType1;
		dbgReq.rd && dbgReq.addr == 12'h048;
	endsequence
	cnt_runs_a: assert property (rdRun ##1 rdRun |=> sysRdata == $past(sysRdata) + 64'h1)
		else $error("counter zero did not step by one");
	cnt_stops_a: assert property (rdStop ##1 rdStop |=> $stable(sysRdata))
		else $error("counter zero moved while clock stopped");
	rd_idle_a: assert property (sysRdata != 64'h0 |-> $past(sysReq.rd))
		else $error("read data without read");
	trap_cause_a: assert property (sysTrap |-> $past(sysReq.rd || sysReq.wr))
		else $error("trap without access");
	top_no_trap_a: assert property (topAcc |=> !sysTrap)
		else $error("top level access trapped");
	type_four_a: assert property (rdType4 |=> sysRdata == 64'hF1)
		else $error("type four not fixed");
	dbg_type_a: assert property (rdDbgType1 |=> dbgRdata == 32'hEF)
		else $error("debug type one wrong");
	dbg_idle_a: assert property (dbgRdata != 32'h0 |-> $past(dbgReq.rd))
		else $error("debug data without read");
	aux_bit_a: assert property (sysReq.rd && sysReq.addr == 12'h0A0 |=> !sysRdata[4])
		else $error("32-bit aux enable bit set");
endmodule

bind acm_activity_monitor acm_activity_monitor_asserts chk_i
(
	.clk      (clk),
	.rst      (rst),
	.events   (events),
	.sysReq   (sysReq),
	.sysRdata (sysRdata),
	.sysTrap  (sysTrap),
	.dbgReq   (dbgReq),
	.dbgRdata (dbgRdata)
);

// File: sim/acm_activity_monitor_test.sv
/*
 * Self-checking bench of the activity counter monitor with a counter model.
 * Assumes acm_pkg, the design and its checker are compiled first.
 */
`timescale 1ns/1ps

module acm_activity_monitor_test;
	logic                 clk;
	logic                 rst;
	acm_pkg::acm_events_t events;
	logic                 constTickToggle;
	acm_pkg::acm_sysreq_t sysReq;
	logic [63:0]          sysRdata;
	logic                 sysTrap;
	acm_pkg::acm_dbgreq_t dbgReq;
	logic [31:0]          dbgRdata;
	logic [63:0]          m [5];
	logic [15:0]          evt [5];
	logic [63:0]          rv;
	logic                 tv;
	logic                 tPrev;
	int                   ms;
	int                   errCount;
	int                   nChecks;
	int                   cyc;
	integer               seed;

	acm_activity_monitor dut
	(
		.clk             (clk),
		.rst             (rst),
		.events          (events),
		.constTickToggle (constTickToggle),
		.sysReq          (sysReq),
		.sysRdata        (sysRdata),
		.sysTrap         (sysTrap),
		.dbgReq          (dbgReq),
		.dbgRdata        (dbgRdata)
	);

	//****************
	// Counter model
	//****************
	always @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			m <= '{default: '0};
			ms <= 0;
			tPrev <= 1'b0;
		end
		else
		begin
			if (events.coreClkRun)
			begin
				m[0] <= m[0] + 64'h1;
				m[2] <= m[2] + 64'(events.instRetired);
				m[4] <= m[4] + 64'(events.powerHint);
				m[3] <= m[3] + 64'(ms == 1);
			end
			m[1] <= m[1] + 64'(constTickToggle != tPrev);
			tPrev <= constTickToggle;
			ms <= (ms == 0 && events.missOutstanding) ? 1 : (ms == 1 && events.missDataReturn) ? 2 :
				(ms == 2 && !events.missOutstanding) ? 0 : ms;
			// Presets from the top level only
			if (sysReq.wr && sysReq.level == 2'h3 && sysReq.addr[11:6] == 6'h00
				&& sysReq.addr[2:0] == 3'h0 && sysReq.addr[5:3] < 3'h5)
			begin
				m[sysReq.addr[5:3]] <= sysReq.wdata;
			end
		end
	end

	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge clk)
	begin
		cyc++;
		if (cyc > 5000)
		begin
			errCount++;
			wrapUp();
		end
	end

	//****************
	// Tasks
	//****************
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		nChecks++;
		if (got !== exp)
		begin
			$display("[ERR] %0t got=%h exp=%h", $time, got, exp);
			errCount++;
		end
	endtask

	task automatic sysAcc(input logic w, input logic [11:0] a, input logic [63:0] d,
		input logic [1:0] lv);
		@(posedge clk);
		sysReq <= '{a, d, w, !w, lv};
		@(posedge clk);
		sysReq.wr <= 1'b0;
		sysReq.rd <= 1'b0;
		#1;
		rv = sysRdata;
		tv = sysTrap;
	endtask

	task automatic sysRd2();
		@(posedge clk);
		sysReq <= '{12'h000, 64'h0, 1'b0, 1'b1, 2'd3};
		@(posedge clk);
		#1;
		rv = sysRdata;
		@(posedge clk);
		sysReq.rd <= 1'b0;
		#1;
	endtask

	task automatic dbgRd(input logic [11:0] a);
		@(posedge clk);
		dbgReq <= '{a, 1'b1};
		@(posedge clk);
		dbgReq.rd <= 1'b0;
		#1;
		rv = {32'h0, dbgRdata};
	endtask

	task automatic act(input int n, input logic run);
		logic [31:0] r;
		for (int i = 0; i < n; i++)
		begin
			r = $random(seed);
			@(posedge clk);
			events.missOutstanding <= run && (i % 16) inside {[8:13]};
			events.missDataReturn <= run && (i % 16) == 11;
			events.coreClkRun <= run && (r[0] || (i % 16) inside {[7:14]});
			events.instRetired <= r[2:1];
			events.powerHint <= r[4:3];
			constTickToggle <= constTickToggle ^ r[5];
		end
		@(posedge clk);
		events <= '0;
		repeat (5) @(posedge clk);
	endtask

	task automatic cmpAll();
		for (int k = 0; k < 5; k++)
		begin
			sysAcc(1'b0, 12'(8 * k), 64'h0, 2'd3);
			chk(rv, m[k]);
			dbgRd(12'(8 * k));
			chk(rv, {32'h0, m[k][31:0]});
			dbgRd(12'(8 * k + 4));
			chk(rv, {32'h0, m[k][63:32]});
		end
	endtask

	task automatic wrapUp();
		$display("checks=%0d errors=%0d", nChecks, errCount);
		if (errCount == 0 && nChecks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	initial
	begin
		seed = 32'h86d4;
		evt = '{16'h0011, 16'h00EF, 16'h0008, 16'h00F0, 16'h00F1};
		rst = 1'b1;
		events = '0;
		constTickToggle = 1'b0;
		sysReq = '0;
		dbgReq = '0;
		errCount = 0;
		nChecks = 0;
		cyc = 0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		sysAcc(1'b0, 12'h080, 64'h0, 2'd3);
		chk(rv, 64'h1F);
		sysAcc(1'b0, 12'h000, 64'h0, 2'd0);
		chk({rv[62:0], tv}, 64'h1);
		sysAcc(1'b1, 12'h098, 64'h10, 2'd3);
		sysAcc(1'b1, 12'h090, 64'h10, 2'd3);
		sysAcc(1'b0, 12'h000, 64'h0, 2'd0);
		chk({rv[62:0], tv}, 64'h0);
		sysAcc(1'b1, 12'h0A0, '1, 2'd0);
		sysAcc(1'b0, 12'h0A0, 64'h0, 2'd0);
		chk(64'(rv[4]), 64'h0);
		sysAcc(1'b0, 12'h0F0, 64'h0, 2'd3);
		chk({rv[62:0], tv}, 64'h0);
		sysAcc(1'b0, 12'h098, 64'h0, 2'h2);
		chk({rv[62:0], tv}, 64'h1);
		sysAcc(1'b1, 12'h0A8, '1, 2'h2);
		sysAcc(1'b0, 12'h0A8, 64'h0, 2'h2);
		chk(rv, 64'h0000_0000_FFFF_FFEF);
		sysAcc(1'b1, 12'h080, 64'h0A, 2'h3);
		sysAcc(1'b1, 12'h080, 64'h0, 2'h2);
		sysAcc(1'b0, 12'h080, 64'h0, 2'h3);
		chk(rv, 64'h0A);
		sysAcc(1'b1, 12'h080, 64'h1F, 2'h3);
		for (int k = 0; k < 5; k++)
		begin
			sysAcc(1'b1, 12'h040 + 12'(8 * k), '1, 2'd3);
			sysAcc(1'b0, 12'h040 + 12'(8 * k), 64'h0, 2'd3);
			chk(rv, 64'(evt[k]));
			dbgRd(12'h040 + 12'(8 * k));
			chk(rv, 64'(evt[k]));
		end
		act(64, 1'b1);
		cmpAll();
		act(64, 1'b0);
		cmpAll();
		sysAcc(1'b1, 12'h000, 64'hFFFF_FFFF_FFFF_FFFE, 2'd3);
		sysAcc(1'b1, 12'h010, 64'h5, 2'd2);
		sysRd2();
		chk(sysRdata, rv);
		@(posedge clk);
		events.coreClkRun <= 1'b1;
		sysRd2();
		chk(sysRdata - rv, 64'h1);
		@(posedge clk);
		events.coreClkRun <= 1'b0;
		act(4, 1'b1);
		cmpAll();
		wrapUp();
	end
endmodule
